// [nvac_pkg.sv]
// package: constants, register map and carrier types for the nonvolatile access path
package nvac_pkg;

   // -----------------------------------------------------------------
   // array geometry and protection granularity
   // -----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int MEM_WORDS = 32768;
   localparam int BLOCK_BYTES = 4096;
   localparam int BLOCK_SHIFT = 12;
   localparam int SEG_W = ADDR_W - BLOCK_SHIFT;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int ARRAY_MAX_HZ = 8000000;
   // extra cycles needed so that each array access sees at most ARRAY_MAX_HZ
   localparam int MIN_WAITS = (CLK_HZ + ARRAY_MAX_HZ - 1) / ARRAY_MAX_HZ - 1;
   localparam int WAIT_W = 3;

   // -----------------------------------------------------------------
   // register offsets (byte addresses on apb)
   // -----------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_BND1 = 12'h004;
   localparam logic [11:0] OFS_BND2 = 12'h008;
   localparam logic [11:0] OFS_PERM = 12'h00c;
   localparam logic [11:0] OFS_STAT = 12'h010;
   localparam logic [11:0] OFS_MASK = 12'h014;

   // control word layout: key in [15:8], wait count in [6:4]
   localparam int KEY_LSB = 8;
   localparam logic [7:0] CTRL_KEY = 8'ha5;
   localparam int WAIT_LSB = 4;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [WAIT_W-1:0] WAIT_RST = 3'h0;
   localparam logic [SEG_W-1:0] BND1_RST = 4'h4;
   localparam logic [SEG_W-1:0] BND2_RST = 4'h8;
   localparam logic [8:0] PERM_RST = 9'h1ff;
   localparam logic [1:0] IRQ_RST = 2'h0;

   // permission bits per segment: [0] read, [1] write, [2] execute
   localparam int PERM_R = 0;
   localparam int PERM_W = 1;
   localparam int PERM_X = 2;
   // status bits
   localparam int ST_VIOL = 0;
   localparam int ST_DONE = 1;

   typedef struct packed {
      logic valid;
      logic write;
      logic fetch;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W/8-1:0] be;
   } nvac_req_t;

   typedef struct packed {
      logic ready;
      logic error;
      logic [DATA_W-1:0] rdata;
   } nvac_rsp_t;

endpackage

// [nvac_prot.sv]
// segment protection check for array accesses
`timescale 1ns/1ps
module nvac_prot (
   input wire logic [nvac_pkg::ADDR_W-1:0] addr,
   input wire logic write,
   input wire logic fetch,
   input wire logic [nvac_pkg::SEG_W-1:0] bnd1,
   input wire logic [nvac_pkg::SEG_W-1:0] bnd2,
   input wire logic [8:0] perm,
   output logic allow
);
   import nvac_pkg::*;

   logic [SEG_W-1:0] blk;
   logic [2:0] p;

   // boundaries compare only the block number, so they move in 4KB steps
   assign blk = addr[ADDR_W-1:BLOCK_SHIFT];

   always_comb begin
      if (blk < bnd1) begin
         p = perm[2:0];
      end else if (blk < bnd2) begin
         p = perm[5:3];
      end else begin
         p = perm[8:6];
      end
   end

   // read-only, read-write, read-execute classes come from the per-segment bits
   always_comb begin
      if (write) begin
         allow = p[PERM_W];
      end else if (fetch) begin
         allow = p[PERM_X];
      end else begin
         allow = p[PERM_R];
      end
   end
endmodule // nvac_prot

// [nvac_top.sv]
// nonvolatile array access path: wait states, write-back, protection, apb registers
// Notes on behaviour
// - above 8 MHz array accesses get only the programmed wait states, 0 after reset; wait_short flags a count too low
// - reads and writes complete directly; any read, write or fetch without its segment right is refused
// - writes change only the addressed bytes, neighbours untouched
// - every allowed read is followed by an invisible write-back of the same data
// - write to read-only segment is suppressed and raises an error flag
// - segments carry read-only, read-write or read-execute rights, movable at run time
// - segment boundaries move in 4KB steps only
// - wait count is accepted only in a write carrying the password key
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module nvac_top (
   input wire logic mclk,
   input wire logic srst,
   input wire nvac_pkg::nvac_req_t req,
   output nvac_pkg::nvac_rsp_t rsp,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   output logic wait_short
);
   import nvac_pkg::*;

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   logic [WAIT_W-1:0] wait_state_count_reg;
   logic [SEG_W-1:0] bnd1_reg;
   logic [SEG_W-1:0] bnd2_reg;
   logic [8:0] perm_reg;
   logic [1:0] stat_reg;
   logic [1:0] mask_reg;
   logic [DATA_W-1:0] mem [MEM_WORDS];

   typedef enum {IDLE, WAIT, ACCESS, WBACK} nvac_state_t;
   nvac_state_t state_reg;
   logic [WAIT_W-1:0] wcnt_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic err_reg;
   logic ready_reg;
   logic [DATA_W-1:0] wb_data_reg;
   logic [ADDR_W-2:0] wb_addr_reg;

   logic apb_wr;
   logic apb_rd;
   logic allow;
   logic viol_ev;
   logic done_ev;
   logic [ADDR_W-2:0] widx;

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                               input logic [DATA_W-1:0] nw,
                                               input logic [DATA_W/8-1:0] be);
      logic [DATA_W-1:0] r;
      r = old;
      for (int i = 0; i < DATA_W/8; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   assign widx = req.addr[ADDR_W-1:1];
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && penable && !pwrite;

   nvac_prot u_prot (
      .addr(req.addr),
      .write(req.write),
      .fetch(req.fetch),
      .bnd1(bnd1_reg),
      .bnd2(bnd2_reg),
      .perm(perm_reg),
      .allow(allow)
   );

   // -----------------------------------------------------------------
   // control register: key-guarded wait count
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         wait_state_count_reg <= WAIT_RST;
      end else if (apb_wr && paddr == OFS_CTRL &&
                   pwdata[KEY_LSB +: 8] == CTRL_KEY) begin
         wait_state_count_reg <= pwdata[WAIT_LSB +: WAIT_W];
      end
   end

   // flags that the programmed count is too low for the running clock
   assign wait_short = (wait_state_count_reg < WAIT_W'(MIN_WAITS));

   // -----------------------------------------------------------------
   // protection registers, rewritable any time
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         bnd1_reg <= BND1_RST;
         bnd2_reg <= BND2_RST;
         perm_reg <= PERM_RST;
      end else if (apb_wr) begin
         if (paddr == OFS_BND1) begin
            bnd1_reg <= pwdata[SEG_W-1:0];
         end
         if (paddr == OFS_BND2) begin
            bnd2_reg <= pwdata[SEG_W-1:0];
         end
         if (paddr == OFS_PERM) begin
            perm_reg <= pwdata[8:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // access sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_reg <= IDLE;
         wcnt_reg <= WAIT_RST;
      end else begin
         case (state_reg)
            IDLE: begin
               if (req.valid && !ready_reg) begin
                  wcnt_reg <= wait_state_count_reg;
                  state_reg <= (wait_state_count_reg == WAIT_RST) ? ACCESS : WAIT;
               end
            end
            WAIT: begin
               wcnt_reg <= wcnt_reg - 3'h1;
               if (wcnt_reg == 3'h1) begin
                  state_reg <= ACCESS;
               end
            end
            ACCESS: begin
               // a read destroys the cells, so an allowed read always goes on to restore them
               state_reg <= (!req.write && allow) ? WBACK : IDLE;
            end
            WBACK: state_reg <= IDLE;
            default: state_reg <= IDLE;
         endcase
      end
   end

   // write-back runs after the core has its data, so it costs the core nothing
   always_ff @(posedge mclk) begin
      // a refused read never touches the cells, so it needs no write-back and leaves rdata_reg holding the previous read
      if (state_reg == ACCESS && !req.write && allow) begin
         rdata_reg <= mem[widx];
         wb_data_reg <= mem[widx];
         wb_addr_reg <= widx;
      end
      if (state_reg == ACCESS && req.write && allow) begin
         mem[widx] <= merge(mem[widx], req.wdata, req.be);
      end else if (state_reg == WBACK) begin
         mem[wb_addr_reg] <= wb_data_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ready_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         ready_reg <= (state_reg == ACCESS);
         err_reg <= (state_reg == ACCESS) && !allow;
      end
   end

   assign rsp.ready = ready_reg;
   assign rsp.error = err_reg;
   assign rsp.rdata = rdata_reg;

   assign viol_ev = (state_reg == ACCESS) && !allow;
   assign done_ev = (state_reg == ACCESS);

   // -----------------------------------------------------------------
   // status, mask and interrupt
   // -----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (srst) begin
         stat_reg <= IRQ_RST;
      end else begin
         // a new event wins over a write-one-to-clear in the same cycle
         stat_reg <= (stat_reg & ~((apb_wr && paddr == OFS_STAT) ? pwdata[1:0] : 2'h0))
                     | {done_ev, viol_ev};
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         mask_reg <= IRQ_RST;
      end else if (apb_wr && paddr == OFS_MASK) begin
         mask_reg <= pwdata[1:0];
      end
   end

   assign irq = |(stat_reg & mask_reg);

   // -----------------------------------------------------------------
   // apb read side, zero-wait answer
   // -----------------------------------------------------------------
   assign pready = 1'b1;

   always_comb begin
      pslverr = 1'b0;
      case (paddr)
         OFS_CTRL: prdata = {24'h0, 1'b0, wait_state_count_reg, 4'h0};
         OFS_BND1: prdata = {28'h0, bnd1_reg};
         OFS_BND2: prdata = {28'h0, bnd2_reg};
         OFS_PERM: prdata = {23'h0, perm_reg};
         OFS_STAT: prdata = {30'h0, stat_reg};
         OFS_MASK: prdata = {30'h0, mask_reg};
         default: begin
            prdata = 32'h0;
            pslverr = psel && penable;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   property p_wait_len;
      @(posedge mclk) disable iff (srst)
      (state_reg == IDLE && req.valid && !ready_reg && wait_state_count_reg == 3'h2)
         |=> (state_reg == WAIT) [*2] ##1 (state_reg == ACCESS);
   endproperty
   a_wait_len: assert property (p_wait_len) else $error("wait length wrong");

   property p_nowait;
      @(posedge mclk) disable iff (srst)
      (state_reg == IDLE && req.valid && !ready_reg && wait_state_count_reg == 3'h0)
         |=> state_reg == ACCESS;
   endproperty
   a_nowait: assert property (p_nowait) else $error("zero wait misbehaves");

   property p_key;
      @(posedge mclk) disable iff (srst)
      (apb_wr && paddr == OFS_CTRL && pwdata[KEY_LSB +: 8] != CTRL_KEY)
         |=> $stable(wait_state_count_reg);
   endproperty
   a_key: assert property (p_key) else $error("keyless write took effect");

   property p_key_ok;
      @(posedge mclk) disable iff (srst)
      (apb_wr && paddr == OFS_CTRL && pwdata[KEY_LSB +: 8] == CTRL_KEY)
         |=> wait_state_count_reg == $past(pwdata[WAIT_LSB +: WAIT_W]);
   endproperty
   a_key_ok: assert property (p_key_ok) else $error("keyed write lost");

   property p_viol;
      @(posedge mclk) disable iff (srst)
      (state_reg == ACCESS && req.write && !allow)
         |=> rsp.error && rsp.ready && stat_reg[ST_VIOL] && $stable(mem[widx]);
   endproperty
   a_viol: assert property (p_viol) else $error("violation not flagged");

   property p_wback;
      @(posedge mclk) disable iff (srst)
      (state_reg == ACCESS && !req.write && allow) |=> state_reg == WBACK ##1 state_reg == IDLE;
   endproperty
   a_wback: assert property (p_wback) else $error("write-back missing");

   property p_restore;
      @(posedge mclk) disable iff (srst)
      (state_reg == WBACK) |=> mem[$past(wb_addr_reg)] == $past(wb_data_reg);
   endproperty
   a_restore: assert property (p_restore) else $error("data not restored");

   property p_direct;
      @(posedge mclk) disable iff (srst)
      (state_reg == ACCESS && allow) |=> rsp.ready && !rsp.error;
   endproperty
   a_direct: assert property (p_direct) else $error("allowed access failed");

   property p_irq;
      @(posedge mclk) disable iff (srst)
      (viol_ev && mask_reg[ST_VIOL]) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   property p_wait_step;
      @(posedge mclk) disable iff (srst)
      (state_reg == WAIT && wcnt_reg != 3'h1)
         |=> state_reg == WAIT && wcnt_reg == $past(wcnt_reg) - 3'h1;
   endproperty
   a_wait_step: assert property (p_wait_step) else $error("wait countdown broken");

   property p_deny_rd;
      @(posedge mclk) disable iff (srst)
      (state_reg == ACCESS && !req.write && !allow)
         |=> rsp.error && rsp.ready && state_reg == IDLE && $stable(rdata_reg);
   endproperty
   a_deny_rd: assert property (p_deny_rd) else $error("refused read leaked");

   c_read: cover property (@(posedge mclk) state_reg == WBACK);
   c_viol: cover property (@(posedge mclk) viol_ev);
   c_wait: cover property (@(posedge mclk) state_reg == WAIT ##1 state_reg == ACCESS);
   c_key: cover property (@(posedge mclk) apb_wr && paddr == OFS_CTRL);

endmodule // nvac_top

// [nvac_core_model.sv]
// model of the cpu core issuing array accesses to the access path
`timescale 1ns/1ps
module nvac_core_model (
   input wire logic mclk,
   input wire logic srst,
   input wire logic go,
   input wire logic wr,
   input wire logic fe,
   input wire logic [15:0] ad,
   input wire logic [15:0] wd,
   input wire logic [1:0] bs,
   output nvac_pkg::nvac_req_t req,
   input wire nvac_pkg::nvac_rsp_t rsp,
   output logic busy,
   output logic [15:0] rdat,
   output logic err,
   output int lat
);
   import nvac_pkg::*;
   int cnt;
   assign busy = req.valid;
   // request held whole until ready; lat counts the stall cycles
   always_ff @(posedge mclk) begin
      if (srst) begin
         req <= '0;
         cnt <= 0;
      end else if (!req.valid) begin
         if (go) begin
            req <= '{valid: 1'h1, write: wr, fetch: fe, addr: ad, wdata: wd, be: bs};
            cnt <= 0;
         end
      end else if (rsp.ready) begin
         // released address and write data lines flip so nothing leans on stale values
         req.valid <= 1'h0;
         req.addr <= ~req.addr;
         req.wdata <= ~req.wdata;
         rdat <= rsp.rdata;
         err <= rsp.error;
         lat <= cnt;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // nvac_core_model

// [tb_top.sv]
// self-checking testbench for the nonvolatile access path
`timescale 1ns/1ps
module tb_top;
   import nvac_pkg::*;
   typedef struct packed {
      logic wr; logic fe; logic [15:0] ad; logic [15:0] wd; logic [1:0] bs;
      logic [15:0] ex; logic er;
   } nvac_row_t;
   logic mclk = 1'h0;
   logic srst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, wait_short, se, busy, err;
   logic go = 1'h0;
   logic wr = 1'h0;
   logic fe = 1'h0;
   logic [15:0] ad = 16'h0;
   logic [15:0] wd = 16'h0;
   logic [1:0] bs = 2'h0;
   logic [15:0] rdat;
   int lat, base;
   int cyc = 0;
   int n_errors = 0;
   int n_checks = 0;
   int nw[4] = '{1, 2, 4, 7};
   logic [11:0] rofs[5] = '{OFS_CTRL, OFS_BND1, OFS_BND2, OFS_PERM, OFS_MASK};
   logic [31:0] rexp[5] = '{32'h0, 32'h4, 32'h8, 32'h1ff, 32'h0};
   nvac_row_t rows[9] = '{
      '{1'h1, 1'h0, 16'h0100, 16'h1234, 2'h3, 16'h0, 1'h0},
      '{1'h0, 1'h0, 16'h0100, 16'h0, 2'h3, 16'h1234, 1'h0},
      '{1'h1, 1'h0, 16'h0100, 16'habcd, 2'h1, 16'h0, 1'h0},
      '{1'h0, 1'h0, 16'h0100, 16'h0, 2'h3, 16'h12cd, 1'h0},
      '{1'h0, 1'h0, 16'h0100, 16'h0, 2'h3, 16'h12cd, 1'h0},
      '{1'h1, 1'h0, 16'h0102, 16'h5555, 2'h2, 16'h0, 1'h0},
      '{1'h0, 1'h0, 16'h0100, 16'h0, 2'h3, 16'h12cd, 1'h0},
      '{1'h1, 1'h0, 16'h2ffe, 16'h0f0f, 2'h3, 16'h0, 1'h0},
      '{1'h0, 1'h1, 16'h2ffe, 16'h0, 2'h3, 16'h0f0f, 1'h0}};
   nvac_req_t req;
   nvac_rsp_t rsp;

   nvac_top i_dut (.mclk(mclk), .srst(srst), .req(req), .rsp(rsp), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .wait_short(wait_short));
   nvac_core_model i_core (.mclk(mclk), .srst(srst), .go(go), .wr(wr), .fe(fe), .ad(ad),
      .wd(wd), .bs(bs), .req(req), .rsp(rsp), .busy(busy), .rdat(rdat), .err(err), .lat(lat));

   always #12.5 mclk = ~mclk;

   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task end_of_test;
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      @(posedge mclk);
      while (pready !== 1'h1) @(posedge mclk);
      rd = prdata;
      se = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // one core access; read data is compared only when the access is allowed
   task acc(input logic w, input logic f, input logic [15:0] a, input logic [15:0] d,
            input logic [1:0] b, input logic [15:0] x, input logic e);
      @(posedge mclk);
      go <= 1'h1;
      wr <= w;
      fe <= f;
      ad <= a;
      wd <= d;
      bs <= b;
      @(posedge mclk);
      go <= 1'h0;
      @(posedge mclk);
      while (busy === 1'h1) @(posedge mclk);
      chk(err, e);
      if (!w && !e) chk(rdat, x);
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end
   end

   // -----------------------------------------------------------------
   // stimulus
   // -----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      chk(wait_short, 1);
      chk(irq, 0);
      foreach (rofs[i]) begin
         apb(0, rofs[i], 0);
         chk(rd, rexp[i]);
      end
      foreach (rows[i]) begin
         acc(rows[i].wr, rows[i].fe, rows[i].ad, rows[i].wd, rows[i].bs, rows[i].ex, rows[i].er);
      end
      acc(0, 0, 16'h0100, 0, 2'h3, 16'h12cd, 0);
      base = lat;
      apb(1, OFS_CTRL, 32'h70);
      apb(0, OFS_CTRL, 0);
      chk(rd, 0);
      foreach (nw[i]) begin
         // wait count goes in before any clock change
         apb(1, OFS_CTRL, {16'h0, CTRL_KEY, 8'h0} | (32'(nw[i]) << WAIT_LSB));
         apb(0, OFS_CTRL, 0);
         chk(rd, 32'(nw[i]) << WAIT_LSB);
         chk(wait_short, nw[i] < 4);
         acc(0, 0, 16'h0100, 0, 2'h3, 16'h12cd, 0);
         chk(lat - base, nw[i]);
      end
      // code below 8k, constants in block 2, variables above
      apb(1, OFS_BND1, 2);
      apb(1, OFS_BND2, 3);
      apb(1, OFS_PERM, 32'h0cd);
      acc(1, 0, 16'h2ffe, 16'h7777, 2'h3, 0, 1);
      acc(0, 0, 16'h2ffe, 0, 2'h3, 16'h0f0f, 0);
      acc(1, 0, 16'h3000, 16'h4242, 2'h3, 0, 0);
      acc(0, 1, 16'h3000, 0, 2'h3, 0, 1);
      acc(0, 0, 16'h3000, 0, 2'h3, 16'h4242, 0);
      acc(1, 0, 16'h1ffe, 16'h0001, 2'h3, 0, 1);
      acc(0, 1, 16'h0100, 0, 2'h3, 16'h12cd, 0);
      acc(0, 1, 16'h2ffe, 0, 2'h3, 0, 1);
      apb(0, OFS_STAT, 0);
      chk(rd, 32'h3);
      chk(irq, 0);
      apb(1, OFS_MASK, 1);
      @(posedge mclk);
      chk(irq, 1);
      apb(1, OFS_STAT, 1);
      @(posedge mclk);
      chk(irq, 0);
      apb(0, OFS_STAT, 0);
      chk(rd, 32'h2);
      apb(0, 12'h020, 0);
      chk(se, 1);
      chk(rd, 0);
      srst <= 1'h1;
      repeat (2) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      chk(wait_short, 1);
      apb(0, OFS_CTRL, 0);
      chk(rd, 0);
      end_of_test();
   end
endmodule // tb_top
